// File: bench/i2crx_bus_master.sv
// Behavioural bus master that drives the clock line and shares the data line.
`timescale 1ns/1ns
module i2crx_bus_master (
	input wire logic sdaOe,
	input wire logic sdaOut,
	output logic scl,
	output wire logic sda
);
	logic mLow = 1'h0;
	initial scl = 1'h1;
	// The pull-up wins whenever nobody pulls, so a released line never keeps a stale value.
	assign sda = !(mLow || (sdaOe && !sdaOut));
	// Odd offsets keep line edges away from system clock edges.
	task automatic startCond();
		#43 mLow = 1'h1;
		#40 scl = 1'h0;
	endtask
	task automatic sendByte(input logic [7:0] d, output logic ack);
		#3;
		for (int i = 0; i < 9; i++) begin
			#40 mLow = i < 8 && !d[7 - i];
			#45 scl = 1'h1;
			#20 ack = sda;
			#20 scl = 1'h0;
		end
	endtask
	task automatic stopCond();
		#43 mLow = 1'h1;
		#45 scl = 1'h1;
		#40 mLow = 1'h0;
		#40;
	endtask
endmodule

// File: bench/i2crx_slave_assertions.sv
// Assertion checker for the two-wire receive block, bound to its top module.
`timescale 1ns/1ns
module i2crx_slave_checker (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [7:0] regRdata,
	input wire logic sclIn,
	input wire logic sdaIn,
	input wire logic sdaOut,
	input wire logic sdaOe,
	input wire logic irq
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	logic en, ovKnown, rdCtl, rdHold;
	logic [2:0] mk;
	wire ctlWr = regWr && regAddr == i2crx_pkg::REG_CONTROL;
	// Shadows of enable and mask let the condition checks stay silent while the block is meant to ignore the bus.
	always_ff @(posedge mclk) begin
		rdCtl <= regRd && regAddr == i2crx_pkg::REG_CONTROL;
		rdHold <= regRd && regAddr == i2crx_pkg::REG_RX_HOLD;
		if (!resetn) begin
			en <= 1'h0;
			mk <= 3'h0;
			ovKnown <= 1'h0;
		end else begin
			if (ctlWr) en <= regWdata[0];
			if (regWr && regAddr == i2crx_pkg::REG_IRQ_MASK) mk <= regWdata[2:0];
			if (ctlWr && !regWdata[2]) ovKnown <= 1'h0;
			else if (rdCtl && regRdata[2]) ovKnown <= 1'h1;
		end
	end
	a_ack_pull_only: assert property (sdaOe |-> !sdaOut) else $error("line driven high");
	a_ack_low_phase: assert property ($changed(sdaOe) |-> !sclIn) else $error("drive moved, clock high");
	a_ack_holds_high: assert property (sdaOe && sclIn |=> sdaOe) else $error("ack cut short");
	a_start_flagged: assert property (en && mk[1] && sclIn && $fell(sdaIn) |-> ##[1:8] irq)
		else $error("start missed");
	a_stop_flagged: assert property (en && mk[2] && sclIn && $rose(sdaIn) |-> ##[1:8] irq)
		else $error("stop missed");
	a_overflow_sticky: assert property (rdCtl && ovKnown |-> regRdata[2]) else $error("overflow lost");
	a_read_clears_full: assert property (rdHold ##1 regRd && regAddr == i2crx_pkg::REG_STATUS |=> !regRdata[0])
		else $error("full not cleared");
	a_mask_silences: assert property (regWr && regAddr == i2crx_pkg::REG_IRQ_MASK && regWdata[2:0] == 3'h0
		|-> ##2 !irq) else $error("masked irq");
	c_ack: cover property ($rose(sdaOe));
	c_overflow: cover property (rdCtl && regRdata[2]);
	c_irq: cover property ($rose(irq));
endmodule
bind i2crx_slave i2crx_slave_checker u_chk (.mclk(mclk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
	.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
	.sdaOe(sdaOe), .irq(irq));

// File: bench/i2crx_slave_tb.sv
// Self-checking bench for the two-wire receive and acknowledge block.
`timescale 1ns/1ns
`define CHK(n, e, g) begin checkCount++; if ((g) !== (e)) begin fails++; $display("wrong value %s expected %h seen %h", n, e, g); end end
module i2crx_slave_tb;
	logic mclk = 1'h0, resetn = 1'h0, regWr = 1'h0, regRd = 1'h0, ack;
	logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, v;
	wire scl, sda, sdaOut, sdaOe, irq;
	int fails = 0, checkCount = 0;
	always #5 mclk = !mclk;
	i2crx_slave u_i2crx_slave (.mclk(mclk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .irq(irq));
	i2crx_bus_master u_i2crx_bus_master (.sdaOe(sdaOe), .sdaOut(sdaOut), .scl(scl), .sda(sda));
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		regWr <= 1'h1;
		regAddr <= a;
		regWdata <= d;
		@(posedge mclk);
		regWr <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		regRd <= 1'h1;
		regAddr <= a;
		@(posedge mclk);
		regRd <= 1'h0;
		#1 v = regRdata;
	endtask
	task automatic xfer(input logic [7:0] d, input logic expAck, input logic expFull);
		wr(8'h10, 8'h01);
		u_i2crx_bus_master.sendByte(d, ack);
		`CHK("ack", expAck, ack)
		rd(8'h10);
		`CHK("byte flag", 1'h1, v[0])
		rd(8'h04);
		`CHK("full", expFull, v[0])
		`CHK("busy", 1'h1, v[1])
		`CHK("last ack", !expAck, v[2])
		`CHK("address hit", 1'h1, v[3])
	endtask
	task automatic irqAfter(input logic [7:0] a, input logic [7:0] d, input logic e);
		wr(a, d);
		@(posedge mclk);
		#1;
		`CHK("irq", e, irq)
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checkCount, fails);
		if (fails == 0 && checkCount > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		repeat (100000) @(posedge mclk);
		fails++;
		finish_test();
	end
	initial begin
		repeat (12) @(posedge mclk);
		resetn <= 1'h1;
		rd(8'h0C);
		`CHK("own address", 8'h2A, v)
		rd(8'hFC);
		`CHK("unmapped", 8'h00, v)
		wr(8'h08, 8'h01);
		wr(8'h14, 8'h07);
		u_i2crx_bus_master.startCond();
		xfer(8'h54, 1'h0, 1'h1);
		xfer(8'hA5, 1'h1, 1'h1);
		rd(8'h08);
		`CHK("control", 8'h05, v)
		rd(8'h00);
		`CHK("hold", 8'h54, v)
		rd(8'h04);
		`CHK("full", 1'h0, v[0])
		xfer(8'h3C, 1'h1, 1'h0);
		wr(8'h08, 8'h05);
		rd(8'h08);
		`CHK("control", 8'h05, v)
		wr(8'h08, 8'h01);
		rd(8'h08);
		`CHK("control", 8'h01, v)
		xfer(8'h3C, 1'h0, 1'h1);
		rd(8'h00);
		`CHK("hold", 8'h3C, v)
		wr(8'h08, 8'h03);
		xfer(8'h77, 1'h1, 1'h0);
		rd(8'h00);
		`CHK("hold", 8'h3C, v)
		u_i2crx_bus_master.stopCond();
		rd(8'h10);
		`CHK("flags", 8'h07, v)
		wr(8'h10, 8'h07);
		wr(8'h08, 8'h01);
		u_i2crx_bus_master.startCond();
		u_i2crx_bus_master.sendByte(8'h55, ack);
		`CHK("read address ack", 1'h1, ack)
		rd(8'h10);
		`CHK("flags", 8'h02, v)
		u_i2crx_bus_master.stopCond();
		rd(8'h10);
		`CHK("flags", 8'h06, v)
		rd(8'h04);
		`CHK("status idle", 8'h00, v)
		irqAfter(8'h14, 8'h00, 1'h0);
		irqAfter(8'h14, 8'h04, 1'h1);
		irqAfter(8'h10, 8'h04, 1'h0);
		finish_test();
	end
endmodule

// File: pkg/i2crx_pkg.sv
// Constants and types shared by the two-wire receive and acknowledge block.
package i2crx_pkg;

	// Register offsets on the plain register port.
	localparam logic [7:0] REG_RX_HOLD = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_CONTROL = 8'h08;
	localparam logic [7:0] REG_OWN_ADDR = 8'h0C;
	localparam logic [7:0] REG_IRQ_FLAGS = 8'h10;
	localparam logic [7:0] REG_IRQ_MASK = 8'h14;

	// Field positions of the control register.
	localparam int CTL_ENABLE = 0;
	localparam int CTL_FW_MASTER = 1;
	localparam int CTL_OVERFLOW = 2;

	// Field positions of the status register.
	localparam int ST_BUF_FULL = 0;
	localparam int ST_BUSY = 1;
	localparam int ST_LAST_ACK = 2;
	localparam int ST_ADDR_HIT = 3;

	// Field positions and width of the interrupt flag and mask registers.
	localparam int IRQ_BYTE = 0;
	localparam int IRQ_START = 1;
	localparam int IRQ_STOP = 2;
	localparam int IRQ_BITS = 3;

	// Widths and counts.
	localparam int DATA_W = 8;
	localparam int SYNC_W = 2;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// Reset values.
	localparam logic [6:0] OWN_ADDR_RESET = 7'h2A;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [2:0] IRQ_RESET = 3'h0;

	typedef enum logic [4:0] {
		I2CRX_IDLE = 5'h01,
		I2CRX_ADDR = 5'h02,
		I2CRX_DATA = 5'h04,
		I2CRX_ACK = 5'h08,
		I2CRX_SKIP = 5'h10
	} i2crx_state_t;

endpackage

// File: src/i2crx_slave.sv
// Two-wire slave receiver with condition detection, acknowledge and holding buffer.
// What this block does
// - With no transfer in progress neither party pulls a line low and both rest high.
// - A falling data line while the clock line is high is detected as a Start.
// - A rising data line while the clock line is high is detected as a Stop.
// - The transmitting party changes the data line only while the clock line is low.
// - A correctly received address or data byte is acknowledged and copied to the holding buffer.
// - With the buffer-full flag already set a byte is neither acknowledged nor copied.
// - With the overflow flag already set a byte is neither acknowledged nor copied.
// - In software-driven master mode there is no automatic acknowledge and no automatic copy.
// - Every matching address byte and every data byte after it sets the port interrupt flag, acknowledged or not.
// - Reading the holding buffer clears the buffer-full flag.
// - The overflow flag stays set until software writes it clear.
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ns
module i2crx_slave (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdata,
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	output logic irq
);

	typedef struct packed {
		i2crx_pkg::i2crx_state_t state;
		logic [3:0] bitCnt;
		logic [7:0] serialShiftRegister;
		logic [7:0] receiveHoldingBuffer;
		logic bufferFullFlag;
		logic receiveOverflowFlag;
		logic fwMaster;
		logic enable;
		logic lastAck;
		logic addrHit;
		logic [6:0] ownAddr;
		logic [2:0] irqFlags;
		logic [2:0] irqMask;
		logic sclQ;
		logic sdaQ;
		logic sdaOut;
		logic sdaOe;
		logic irq;
		logic [7:0] rdata;
	} i2crx_regs_t;

	i2crx_regs_t q_r;
	i2crx_regs_t q_nxt;
	logic [1:0] lineSync;
	logic sclS;
	logic sdaS;
	logic sclRise;
	logic sclFall;
	logic startSeen;
	logic stopSeen;
	logic byteDone;
	logic addrMatch;
	logic accept;
	logic [2:0] irqSet;
	logic [7:0] statusWord;
	logic [7:0] controlWord;
	logic ovSet;

	// Start and Stop differ only in the direction of the data edge.
	function automatic logic lineCondition(
		input logic sclNow,
		input logic sclWas,
		input logic sdaWas,
		input logic sdaNow
	);
		lineCondition = sclNow && sclWas && (sdaWas != sdaNow);
	endfunction

	// Refusal reasons are checked in one place so the acknowledge and the copy can never disagree.
	function automatic logic byteAccepted(
		input logic bufFull,
		input logic overflow,
		input logic fwMaster
	);
		byteAccepted = !bufFull && !overflow && !fwMaster;
	endfunction

	// A refusal is an overflow only when software left the buffer full, not when it runs the port itself.
	function automatic logic overflowOnRefuse(
		input logic bufFull,
		input logic fwMaster
	);
		overflowOnRefuse = bufFull && !fwMaster;
	endfunction

	function automatic logic [7:0] padFlags(
		input logic [2:0] flags
	);
		padFlags = {5'h00, flags};
	endfunction

	i2crx_sync u_sync (
		.mclk(mclk),
		.resetn(resetn),
		.pinIn({sclIn, sdaIn}),
		.pinSync(lineSync)
	);

	assign sclS = lineSync[1];
	assign sdaS = lineSync[0];

	always_comb begin
		sclRise = sclS && !q_r.sclQ;
		sclFall = !sclS && q_r.sclQ;
		// Conditions are judged on stable clock high, so data moved while the clock is low never looks like one.
		startSeen = lineCondition(sclS, q_r.sclQ, q_r.sdaQ, sdaS) && !sdaS;
		stopSeen = lineCondition(sclS, q_r.sclQ, q_r.sdaQ, sdaS) && sdaS;
		byteDone = sclFall && (q_r.bitCnt == i2crx_pkg::BITS_PER_BYTE);
		addrMatch = (q_r.serialShiftRegister[7:1] == q_r.ownAddr) && !q_r.serialShiftRegister[0];
		accept = byteAccepted(q_r.bufferFullFlag, q_r.receiveOverflowFlag, q_r.fwMaster);
	end

	always_comb begin
		statusWord = 8'h00;
		statusWord[i2crx_pkg::ST_BUF_FULL] = q_r.bufferFullFlag;
		statusWord[i2crx_pkg::ST_BUSY] = (q_r.state != i2crx_pkg::I2CRX_IDLE);
		statusWord[i2crx_pkg::ST_LAST_ACK] = q_r.lastAck;
		statusWord[i2crx_pkg::ST_ADDR_HIT] = q_r.addrHit;
		controlWord = 8'h00;
		controlWord[i2crx_pkg::CTL_ENABLE] = q_r.enable;
		controlWord[i2crx_pkg::CTL_FW_MASTER] = q_r.fwMaster;
		controlWord[i2crx_pkg::CTL_OVERFLOW] = q_r.receiveOverflowFlag;
	end

	always_comb begin
		q_nxt = q_r;
		irqSet = i2crx_pkg::IRQ_RESET;
		ovSet = 1'b0;
		q_nxt.sclQ = sclS;
		q_nxt.sdaQ = sdaS;
		q_nxt.rdata = 8'h00;

		// Bus side.
		if (!q_r.enable) begin
			q_nxt.state = i2crx_pkg::I2CRX_IDLE;
			q_nxt.sdaOe = 1'b0;
		end else if (startSeen) begin
			// A repeated Start restarts address reception from any state.
			q_nxt.state = i2crx_pkg::I2CRX_ADDR;
			q_nxt.bitCnt = 4'h0;
			q_nxt.sdaOe = 1'b0;
			q_nxt.addrHit = 1'b0;
			irqSet[i2crx_pkg::IRQ_START] = 1'b1;
		end else if (stopSeen) begin
			q_nxt.state = i2crx_pkg::I2CRX_IDLE;
			q_nxt.sdaOe = 1'b0;
			irqSet[i2crx_pkg::IRQ_STOP] = 1'b1;
		end else begin
			unique case (q_r.state)
				i2crx_pkg::I2CRX_IDLE: begin
					q_nxt.sdaOe = 1'b0;
				end
				i2crx_pkg::I2CRX_ADDR,
				i2crx_pkg::I2CRX_DATA: begin
					if (sclRise && (q_r.bitCnt != i2crx_pkg::BITS_PER_BYTE)) begin
						q_nxt.serialShiftRegister = {q_r.serialShiftRegister[6:0], sdaS};
						q_nxt.bitCnt = q_r.bitCnt + 4'h1;
					end
					if (byteDone) begin
						if ((q_r.state == i2crx_pkg::I2CRX_ADDR) && !addrMatch) begin
							// Another slave is addressed, or a read: keep off the bus until the next condition.
							q_nxt.state = i2crx_pkg::I2CRX_SKIP;
						end else begin
							q_nxt.state = i2crx_pkg::I2CRX_ACK;
							q_nxt.addrHit = 1'b1;
							q_nxt.lastAck = accept;
							irqSet[i2crx_pkg::IRQ_BYTE] = 1'b1;
							if (accept) begin
								q_nxt.receiveHoldingBuffer = q_r.serialShiftRegister;
								q_nxt.bufferFullFlag = 1'b1;
								q_nxt.sdaOe = 1'b1;
							end else begin
								q_nxt.sdaOe = 1'b0;
								if (overflowOnRefuse(q_r.bufferFullFlag, q_r.fwMaster)) begin
									ovSet = 1'b1;
									q_nxt.receiveOverflowFlag = 1'b1;
								end
							end
						end
					end
				end
				i2crx_pkg::I2CRX_ACK: begin
					if (sclFall) begin
						// The ninth pulse has ended, so the line is handed back before the master's next bit.
						q_nxt.sdaOe = 1'b0;
						q_nxt.bitCnt = 4'h0;
						q_nxt.state = i2crx_pkg::I2CRX_DATA;
					end
				end
				i2crx_pkg::I2CRX_SKIP: begin
					q_nxt.sdaOe = 1'b0;
				end
				default: begin
					q_nxt.state = i2crx_pkg::I2CRX_IDLE;
					q_nxt.sdaOe = 1'b0;
				end
			endcase
		end

		// Register side.
		if (regRd) begin
			unique case (regAddr)
				i2crx_pkg::REG_RX_HOLD: begin
					q_nxt.rdata = q_r.receiveHoldingBuffer;
					// A byte taken in this same cycle keeps the flag set, so it is not lost behind the old one.
					q_nxt.bufferFullFlag = q_nxt.bufferFullFlag && !q_r.bufferFullFlag;
				end
				i2crx_pkg::REG_STATUS: begin
					q_nxt.rdata = statusWord;
				end
				i2crx_pkg::REG_CONTROL: begin
					q_nxt.rdata = controlWord;
				end
				i2crx_pkg::REG_OWN_ADDR: begin
					q_nxt.rdata = {1'b0, q_r.ownAddr};
				end
				i2crx_pkg::REG_IRQ_FLAGS: begin
					q_nxt.rdata = padFlags(q_r.irqFlags);
				end
				i2crx_pkg::REG_IRQ_MASK: begin
					q_nxt.rdata = padFlags(q_r.irqMask);
				end
				default: begin
					q_nxt.rdata = 8'h00;
				end
			endcase
		end

		if (regWr) begin
			unique case (regAddr)
				i2crx_pkg::REG_CONTROL: begin
					q_nxt.enable = regWdata[i2crx_pkg::CTL_ENABLE];
					q_nxt.fwMaster = regWdata[i2crx_pkg::CTL_FW_MASTER];
					// Software may only clear the overflow flag, and a new overflow in the same cycle wins.
					if (!regWdata[i2crx_pkg::CTL_OVERFLOW] && !ovSet) begin
						q_nxt.receiveOverflowFlag = 1'b0;
					end
				end
				i2crx_pkg::REG_OWN_ADDR: begin
					q_nxt.ownAddr = regWdata[6:0];
				end
				i2crx_pkg::REG_IRQ_FLAGS: begin
					q_nxt.irqFlags = q_r.irqFlags & ~regWdata[2:0];
				end
				i2crx_pkg::REG_IRQ_MASK: begin
					q_nxt.irqMask = regWdata[2:0];
				end
				default: begin
					q_nxt.irqMask = q_r.irqMask;
				end
			endcase
		end

		// A hardware event beats a clear written in the same cycle.
		q_nxt.irqFlags = q_nxt.irqFlags | irqSet;
		q_nxt.irq = |(q_nxt.irqFlags & q_nxt.irqMask);
		q_nxt.sdaOut = 1'b0;
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			q_r.state <= i2crx_pkg::I2CRX_IDLE;
			q_r.bitCnt <= 4'h0;
			q_r.serialShiftRegister <= i2crx_pkg::DATA_RESET;
			q_r.receiveHoldingBuffer <= i2crx_pkg::DATA_RESET;
			q_r.bufferFullFlag <= 1'b0;
			q_r.receiveOverflowFlag <= 1'b0;
			q_r.fwMaster <= 1'b0;
			q_r.enable <= 1'b0;
			q_r.lastAck <= 1'b0;
			q_r.addrHit <= 1'b0;
			q_r.ownAddr <= i2crx_pkg::OWN_ADDR_RESET;
			q_r.irqFlags <= i2crx_pkg::IRQ_RESET;
			q_r.irqMask <= i2crx_pkg::IRQ_RESET;
			q_r.sclQ <= 1'b1;
			q_r.sdaQ <= 1'b1;
			q_r.sdaOut <= 1'b0;
			q_r.sdaOe <= 1'b0;
			q_r.irq <= 1'b0;
			q_r.rdata <= 8'h00;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign regRdata = q_r.rdata;
	assign sdaOut = q_r.sdaOut;
	assign sdaOe = q_r.sdaOe;
	assign irq = q_r.irq;

endmodule

// File: src/i2crx_sync.sv
// Two-flop synchroniser for the bus lines sampled by the system clock.
`timescale 1ns/1ns
module i2crx_sync (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [i2crx_pkg::SYNC_W-1:0] pinIn,
	output logic [i2crx_pkg::SYNC_W-1:0] pinSync
);

	logic [i2crx_pkg::SYNC_W-1:0] meta_r;

	// Lines idle high, so reset to high avoids false edges after release.
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			meta_r <= '1;
			pinSync <= '1;
		end else begin
			meta_r <= pinIn;
			pinSync <= meta_r;
		end
	end

endmodule
